// file: dspu_baud.sv
// Bit clock generator: reference clock synthesis and divisor.
// Assumes divisor and range select are stable in the CLK domain.
`timescale 1ns/1ns
module dspu_baud
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        quad_sel,
  input  wire logic [15:0] divisor,
  output logic             tick
);

  logic [23:0] acc_r;
  logic [15:0] cnt_r;
  logic        ref_tick;
  logic [23:0] acc_nxt;
  logic        div_wrap;

  // ----------------------------------------
  // Reference clock by phase accumulator
  // ----------------------------------------
  // Carry jitters by one CLK period; 32 ticks per bit hide it
  assign {ref_tick, acc_nxt} = {1'b0, acc_r}
                             + {1'b0, (quad_sel ? dspu_pkg::INC_QUAD : dspu_pkg::INC_BASE)}; // RL4
  // A zero divisor stops the bit clock
  assign div_wrap = (divisor != 16'h0000) && (cnt_r >= divisor - 16'h0001);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      acc_r <= 24'h000000;
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      tick  <= ref_tick & div_wrap; // RL3
      if (ref_tick)
        cnt_r <= div_wrap ? 16'h0000 : cnt_r + 16'h0001; // RL3
    end
  end

endmodule

// file: dspu_far_end.sv
// Remote node on the differential pairs: frames characters onto the
// receive pair, captures the port's transmit pair. Line idles at mark.
`timescale 1ns/1ns
module dspu_far_end
(
  input  wire logic  txd,
  input  real        bit_ns,
  input  int         len,
  output logic       rxd,
  output logic [7:0] got
);
  int i;
  initial rxd = 1'b1;
  // Centre sampling, LSB first; right-aligned
  always
  begin
    @(negedge txd);
    got = 8'h00;
    #(bit_ns * 1.5);
    for (i = 0; i < len; i++)
    begin
      got[i] = txd;
      #(bit_ns);
    end
  end
  // Parity off, so stop follows data directly
  task automatic send(input logic [7:0] b);
    int j;
    rxd = 1'b0;
    #(bit_ns);
    for (j = 0; j < 8; j++)
    begin
      rxd = b[j];
      #(bit_ns);
    end
    rxd = 1'b1;
    #(bit_ns * 2.0);
  endtask
endmodule

// file: dspu_pkg.sv
// Constants and carrier types for the differential serial port.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.
package dspu_pkg;

  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  localparam longint unsigned CLK_HZ      = 64'd10000000;
  localparam longint unsigned REF_BASE_HZ = 64'd1843200;
  localparam longint unsigned REF_QUAD_HZ = 64'd7372800;
  localparam int              ACC_W       = 24;
  localparam logic [23:0] INC_BASE = 24'((REF_BASE_HZ << ACC_W) / CLK_HZ);
  localparam logic [23:0] INC_QUAD = 24'((REF_QUAD_HZ << ACC_W) / CLK_HZ);
  localparam logic [4:0]  TICK_LAST = 5'h1F;
  localparam logic [4:0]  TICK_MID  = 5'h0F;

  // ----------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [3:0] IDX_DATA   = 4'h0;
  localparam logic [3:0] IDX_DIVH   = 4'h1;
  localparam logic [3:0] IDX_IDENT  = 4'h2;
  localparam logic [3:0] IDX_LCTRL  = 4'h3;
  localparam logic [3:0] IDX_MODE   = 4'h4;
  localparam logic [3:0] IDX_LSTAT  = 4'h5;
  localparam logic [3:0] IDX_EVT    = 4'h6;
  localparam logic [3:0] IDX_EVMASK = 4'h7;
  localparam logic [3:0] IDX_SHARED = 4'h8;

  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int LS_DR   = 0;
  localparam int LS_OE   = 1;
  localparam int LS_PE   = 2;
  localparam int LS_FE   = 3;
  localparam int LS_THRE = 5;
  localparam int LS_TEMT = 6;
  localparam int EV_RX   = 0;
  localparam int EV_TXE  = 1;
  localparam int EV_ERR  = 2;
  localparam logic [7:0] IDENT_RX   = 8'h04;
  localparam logic [7:0] IDENT_NONE = 8'h01;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_DIV   = 16'h000C;
  localparam logic [7:0]  RST_LCTRL = 8'h00;
  localparam logic [2:0]  RST_EVMSK = 3'h0;

  typedef struct packed {
    logic       divisor_access_bit;
    logic       brk;
    logic       stick;
    logic       even;
    logic       pen;
    logic       stop2;
    logic [1:0] wls;
  } dspu_lctrl_t;

  typedef struct packed {
    logic [7:0] data;
    logic       perr;
    logic       ferr;
  } dspu_rxchar_t;

endpackage

// file: dspu_uart.sv
// One serial port: APB registers, framer, receiver, driver control.
// Assumes RXD and the range strap are asynchronous to CLK.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns

// Overview of operation
// RL1 - Line control bit 7 swaps offsets 0 and 1 to the divisor.
// RL2 - Divisor access on: offset 0 writes low byte, offset 1 high byte.
// RL3 - Bit rate is reference clock over thirty-two times the divisor.
// RL4 - Reference is 1.8432 MHz base range, 7.3728 MHz quad range.
// RL5 - Software writes divisor 0x0C, high zero, for 4800 baud on base.
// RL6 - Line control bits 0-1 give length minus five, 5 to 8 bits.
// RL7 - Line control bit 2 clear: one stop bit; set: two.
// RL8 - Line control bits 3-6 give parity and break; software keeps zero.
// RL9 - Software clears divisor access after loading or data stays hidden.
// RL10 - Software reads the receive buffer twice to flush at startup.
// RL11 - Line status bit 0 flags a waiting character, read at offset 0.
// RL12 - Line status 0x20 flags transmitter ready; software waits for it.
// RL13 - Identification at offset 2 reads 4 for receive data, else none.
// RL14 - Two-wire mode enables the driver whenever transmit data pend.
// RL15 - Shared status at offset 8 shows which port requests interrupt.
// RL16 - Reading the buffer clears data ready unless a new one arrives.
// RL17 - Driver released after the last stop bit of the last character.
module dspu_uart
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RXD,
  input  wire logic        QUAD_RANGE,
  output logic             TXD,
  output logic             TX_DRIVE_EN,
  output logic             IRQ
);

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} dspu_rxst_t;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} dspu_txst_t;

  logic                 rxd_s1_r;
  logic                 rxd_s2_r;
  logic                 quad_s1_r;
  logic                 quad_s2_r;
  logic [15:0]          div_r;
  dspu_pkg::dspu_lctrl_t lctrl_r;
  logic                 rx_ien_r;
  logic                 two_wire_r;
  logic [2:0]           evt_r;
  logic [2:0]           evmask_r;
  logic [7:0]           rbuf_r;
  logic                 dr_r;
  logic                 oe_r;
  logic                 pe_r;
  logic                 fe_r;
  logic [7:0]           hold_r;
  logic                 hold_full_r;
  dspu_rxst_t           rx_st_r;
  logic [4:0]           rx_cnt_r;
  logic [2:0]           rx_bit_r;
  logic [7:0]           rx_sh_r;
  logic                 rx_perr_r;
  dspu_txst_t           tx_st_r;
  logic [4:0]           tx_cnt_r;
  logic [2:0]           tx_bit_r;
  logic [7:0]           tx_sh_r;
  logic                 tx_par_r;
  logic                 tx_stop_r;
  logic                 tick;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      rxd_s1_r  <= 1'b1;
      rxd_s2_r  <= 1'b1;
      quad_s1_r <= 1'b0;
      quad_s2_r <= 1'b0;
    end
    else
    begin
      rxd_s1_r  <= RXD;
      rxd_s2_r  <= rxd_s1_r;
      quad_s1_r <= QUAD_RANGE;
      quad_s2_r <= quad_s1_r;
    end
  end

  dspu_baud u_baud
  (
    .clk      (CLK),
    .reset    (RESET),
    .quad_sel (quad_s2_r),
    .divisor  (div_r),
    .tick     (tick)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire [3:0] idx      = PADDR[5:2];
  wire       mapped   = (PADDR[7:6] == 2'b00) && (PADDR[1:0] == 2'b00)
                        && (idx <= dspu_pkg::IDX_SHARED);
  wire       acc_req  = PSEL & PENABLE & ~PREADY;
  wire       acc_done = PSEL & PENABLE & PREADY & mapped;
  wire       wr       = acc_done & PWRITE;
  wire       rd       = acc_done & ~PWRITE;
  wire       divisor_access_bit     = lctrl_r.divisor_access_bit;
  wire       wr_divl  = wr & (idx == dspu_pkg::IDX_DATA) & divisor_access_bit; // RL2
  wire       wr_divh  = wr & (idx == dspu_pkg::IDX_DIVH) & divisor_access_bit; // RL2
  wire       wr_thr   = wr & (idx == dspu_pkg::IDX_DATA) & ~divisor_access_bit; // RL1
  wire       wr_ien   = wr & (idx == dspu_pkg::IDX_DIVH) & ~divisor_access_bit; // RL1
  wire       wr_lctrl = wr & (idx == dspu_pkg::IDX_LCTRL);
  wire       wr_mode  = wr & (idx == dspu_pkg::IDX_MODE);
  wire       wr_evt   = wr & (idx == dspu_pkg::IDX_EVT);
  wire       wr_evmsk = wr & (idx == dspu_pkg::IDX_EVMASK);
  wire       rd_rbuf  = rd & (idx == dspu_pkg::IDX_DATA) & ~divisor_access_bit; // RL11
  wire       rd_lstat = rd & (idx == dspu_pkg::IDX_LSTAT);

  // ----------------------------------------
  // Status views
  // ----------------------------------------
  wire       tx_idle  = (tx_st_r == TX_IDLE);
  wire       rx_int   = dr_r & rx_ien_r;
  wire [7:0] ident    = rx_int ? dspu_pkg::IDENT_RX : dspu_pkg::IDENT_NONE; // RL13
  wire [7:0] lstat    = {1'b0, ~hold_full_r & tx_idle, ~hold_full_r, 1'b0,
                         fe_r, pe_r, oe_r, dr_r}; // RL11 RL12
  wire [7:0] rd_lo    = (idx == dspu_pkg::IDX_DATA)   ? (divisor_access_bit ? div_r[7:0] : rbuf_r) :
                        (idx == dspu_pkg::IDX_DIVH)   ? (divisor_access_bit ? div_r[15:8]
                                                              : {7'h00, rx_ien_r}) :
                        (idx == dspu_pkg::IDX_IDENT)  ? ident :
                        (idx == dspu_pkg::IDX_LCTRL)  ? lctrl_r :
                        (idx == dspu_pkg::IDX_MODE)   ? {7'h00, two_wire_r} :
                        (idx == dspu_pkg::IDX_LSTAT)  ? lstat :
                        (idx == dspu_pkg::IDX_EVT)    ? {5'h00, evt_r} :
                        (idx == dspu_pkg::IDX_EVMASK) ? {5'h00, evmask_r} :
                        {7'h00, IRQ | rx_int}; // RL15
  wire [31:0] rdata   = mapped ? {24'h000000, rd_lo} : 32'h00000000;

  // One wait state; data captured with the ready flop
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end
    else
    begin
      PREADY  <= acc_req;
      PSLVERR <= acc_req & ~mapped;
      if (acc_req & ~PWRITE)
        PRDATA <= rdata;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      div_r      <= dspu_pkg::RST_DIV;
      lctrl_r    <= dspu_pkg::RST_LCTRL;
      rx_ien_r   <= 1'b0;
      two_wire_r <= 1'b0;
      evmask_r   <= dspu_pkg::RST_EVMSK;
    end
    else
    begin
      if (wr_divl)
        div_r[7:0] <= PWDATA[7:0]; // RL2
      if (wr_divh)
        div_r[15:8] <= PWDATA[7:0]; // RL2
      if (wr_lctrl)
        lctrl_r <= PWDATA[7:0]; // RL1
      if (wr_ien)
        rx_ien_r <= PWDATA[0];
      if (wr_mode)
        two_wire_r <= PWDATA[0];
      if (wr_evmsk)
        evmask_r <= PWDATA[2:0];
    end
  end

  // ----------------------------------------
  // Receiver, 32 ticks per bit, sampled mid-bit
  // ----------------------------------------
  wire [2:0] last_bit = {1'b0, lctrl_r.wls} + 3'h4; // RL6
  wire       rx_edge  = tick & (rx_cnt_r == dspu_pkg::TICK_LAST);
  wire       rx_done  = rx_edge & (rx_st_r == RX_STOP);
  wire [7:0] rx_align = rx_sh_r >> (2'h3 - lctrl_r.wls); // RL6
  dspu_pkg::dspu_rxchar_t rx_char;
  assign rx_char = '{data: rx_align, perr: rx_perr_r, ferr: ~rxd_s2_r};
  wire       par_calc = ^rx_align;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      rx_st_r   <= RX_IDLE;
      rx_cnt_r  <= 5'h00;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_perr_r <= 1'b0;
    end
    else if (tick)
    begin
      rx_cnt_r <= rx_cnt_r + 5'h01;
      case (rx_st_r)
        RX_IDLE:
        begin
          rx_cnt_r <= 5'h00;
          if (!rxd_s2_r)
            rx_st_r <= RX_START;
        end
        RX_START:
          if (rx_cnt_r == dspu_pkg::TICK_MID)
          begin
            rx_cnt_r  <= 5'h00;
            rx_bit_r  <= 3'h0;
            rx_perr_r <= 1'b0;
            rx_st_r   <= rxd_s2_r ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_edge)
          begin
            rx_sh_r  <= {rxd_s2_r, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit)
              rx_st_r <= lctrl_r.pen ? RX_PAR : RX_STOP; // RL8
          end
        RX_PAR:
          if (rx_edge)
          begin
            rx_perr_r <= rxd_s2_r != (lctrl_r.stick ? ~lctrl_r.even
                                                    : par_calc ^ ~lctrl_r.even); // RL8
            rx_st_r   <= RX_STOP;
          end
        RX_STOP:
          if (rx_edge)
            rx_st_r <= RX_IDLE;
        default:
          rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // Arrival beats a read in the same cycle
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      rbuf_r <= 8'h00;
      dr_r   <= 1'b0;
      oe_r   <= 1'b0;
      pe_r   <= 1'b0;
      fe_r   <= 1'b0;
    end
    else
    begin
      if (rx_done)
        rbuf_r <= rx_char.data; // RL11
      dr_r <= rx_done | (dr_r & ~rd_rbuf); // RL16
      oe_r <= (rx_done & dr_r & ~rd_rbuf) | (oe_r & ~rd_lstat);
      pe_r <= (rx_done & rx_char.perr) | (pe_r & ~rd_lstat);
      fe_r <= (rx_done & rx_char.ferr) | (fe_r & ~rd_lstat);
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  wire       tx_load  = tx_idle & hold_full_r;
  wire       tx_edge  = tick & (tx_cnt_r == dspu_pkg::TICK_LAST);
  wire [7:0] tx_mask  = 8'hFF >> (2'h3 - lctrl_r.wls); // RL6
  wire       tx_pbit  = lctrl_r.stick ? ~lctrl_r.even
                                      : ^(hold_r & tx_mask) ^ ~lctrl_r.even; // RL8
  wire       txd_nxt  = (tx_st_r == TX_START) ? 1'b0 :
                        (tx_st_r == TX_DATA)  ? tx_sh_r[0] :
                        (tx_st_r == TX_PAR)   ? tx_par_r : 1'b1;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      hold_r      <= 8'h00;
      hold_full_r <= 1'b0;
    end
    else
    begin
      if (wr_thr)
        hold_r <= PWDATA[7:0];
      hold_full_r <= wr_thr | (hold_full_r & ~tx_load); // RL12
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      tx_st_r   <= TX_IDLE;
      tx_cnt_r  <= 5'h00;
      tx_bit_r  <= 3'h0;
      tx_sh_r   <= 8'h00;
      tx_par_r  <= 1'b0;
      tx_stop_r <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_st_r  <= TX_START;
      tx_cnt_r <= 5'h00;
      tx_bit_r <= 3'h0;
      tx_sh_r  <= hold_r;
      tx_par_r <= tx_pbit;
    end
    else if (tick)
    begin
      tx_cnt_r <= tx_cnt_r + 5'h01;
      case (tx_st_r)
        TX_IDLE:
          tx_cnt_r <= 5'h00;
        TX_START:
          if (tx_edge)
            tx_st_r <= TX_DATA;
        TX_DATA:
          if (tx_edge)
          begin
            tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == last_bit) // RL6
            begin
              tx_stop_r <= lctrl_r.stop2; // RL7
              tx_st_r   <= lctrl_r.pen ? TX_PAR : TX_STOP; // RL8
            end
          end
        TX_PAR:
          if (tx_edge)
            tx_st_r <= TX_STOP;
        TX_STOP:
          if (tx_edge)
          begin
            tx_stop_r <= 1'b0;
            if (!tx_stop_r)
              tx_st_r <= TX_IDLE; // RL7
          end
        default:
          tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Line and driver outputs
  // ----------------------------------------
  // Four-wire lines keep the driver on; two-wire shares the pair
  wire de_nxt = ~two_wire_r | hold_full_r | ~tx_idle; // RL14 RL17

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      TXD         <= 1'b1;
      TX_DRIVE_EN <= 1'b0;
    end
    else
    begin
      TXD         <= lctrl_r.brk ? 1'b0 : txd_nxt; // RL8
      TX_DRIVE_EN <= de_nxt; // RL14 RL17
    end
  end

  // ----------------------------------------
  // Event status and interrupt
  // ----------------------------------------
  wire [2:0] ev_set = {rx_done & (rx_char.perr | rx_char.ferr | dr_r),
                       tx_load, rx_done};
  wire [2:0] ev_clr = wr_evt ? PWDATA[2:0] : 3'h0;

  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      evt_r <= 3'h0;
      IRQ   <= 1'b0;
    end
    else
    begin
      evt_r <= (evt_r & ~ev_clr) | ev_set;
      IRQ   <= |(evt_r & evmask_r);
    end
  end

endmodule

// file: dspu_uart_monitor.sv
// Concurrent checks on the serial port's APB and line pins.
// Bound to every dspu_uart instance; sees its ports only.
`timescale 1ns/1ns
module dspu_uart_monitor
(
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RXD,
  input wire logic        QUAD_RANGE,
  input wire logic        TXD,
  input wire logic        TX_DRIVE_EN,
  input wire logic        IRQ
);
  // ----------------------------------------
  // Access phases
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_done;
    PSEL && PENABLE && PREADY;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ready_one_wait: assert property (s_wait |=> PREADY)
    else $error("ready late");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  a_err_unmapped: assert property (s_wait |=> PSLVERR == (PADDR[5:2] > 4'h8))
    else $error("error flag wrong");
  a_err_read_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("error read data");
  a_ident_values: assert property (s_done and (!PWRITE && PADDR[5:2] == 4'h2)
    |-> PRDATA == 32'h4 || PRDATA == 32'h1) else $error("ident value");
  a_line_driven: assert property (!TXD |-> TX_DRIVE_EN)
    else $error("driver off in frame");
  a_release_idle: assert property ($fell(TX_DRIVE_EN) |-> TXD && $past(TXD, 2))
    else $error("driver off early");
  a_start_hold: assert property ($fell(TXD) |-> !TXD [*8])
    else $error("start bit short");
  a_reset_idle: assert property (disable iff (1'b0)
    RESET |=> TXD && !IRQ && !PREADY && !TX_DRIVE_EN) else $error("reset state");
endmodule

bind dspu_uart dspu_uart_monitor i_dspu_uart_monitor
(
  .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .RXD(RXD), .QUAD_RANGE(QUAD_RANGE), .TXD(TXD),
  .TX_DRIVE_EN(TX_DRIVE_EN), .IRQ(IRQ)
);

// file: tb.sv
// Self-checking bench for one serial port over APB.
// Assumes the far-end model and the bound monitor.
`timescale 1ns/1ns
module tb;
  logic        CLK, RESET, PSEL, PENABLE, PWRITE, QUAD_RANGE;
  logic        RXD, TXD, TX_DRIVE_EN, IRQ, PREADY, PSLVERR;
  logic [7:0]  PADDR, far_got;
  logic [31:0] PWDATA, PRDATA;
  real         bit_ns;
  int          far_len, mismatches, comparisons, n;

  dspu_uart i_dspu_uart
  (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RXD(RXD), .QUAD_RANGE(QUAD_RANGE), .TXD(TXD),
    .TX_DRIVE_EN(TX_DRIVE_EN), .IRQ(IRQ)
  );
  dspu_far_end i_dspu_far_end
  (
    .txd(TXD), .bit_ns(bit_ns), .len(far_len), .rxd(RXD), .got(far_got)
  );

  always #50 CLK = ~CLK;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Called just after a rising edge; returns one edge after release
  task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {2'h0, idx, 2'h0};
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    // Values read here are those sampled at this rising edge
    do
    begin
      @(posedge CLK);
      k++;
    end
    while (PREADY !== 1'b1 && k < 50);
    chk({31'h0, PREADY}, 32'h1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] v;
    logic        e;
    apb(1'b1, idx, d, v, e);
  endtask
  task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    logic        e;
    apb(1'b0, idx, 8'h00, v, e);
    chk(v, exp);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim)
    begin
      @(negedge CLK);
      k++;
    end
    chk({31'h0, s}, {31'h0, v});
  endtask
  task automatic set_div(input logic [7:0] d, input logic q);
    QUAD_RANGE <= q;
    bit_ns = 32.0 * d * 1.0e9 / (q ? 7372800.0 : 1843200.0);
    wr(4'h3, 8'h80);
    wr(4'h0, d);
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h03);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] v;
    logic        e;
    rd(4'h3, 32'h0);
    rd(4'h5, 32'h60);
    rd(4'h2, 32'h1);
    wr(4'h3, 8'h80);
    rd(4'h0, 32'h0C);
    wr(4'h0, 8'h34);
    wr(4'h1, 8'h12);
    rd(4'h0, 32'h34);
    rd(4'h1, 32'h12);
    wr(4'h3, 8'h03);
    rd(4'h1, 32'h0);
    rd(4'h0, 32'h0);
    rd(4'h0, 32'h0);
    wr(4'h5, 8'hFF);
    rd(4'h5, 32'h60);
    apb(1'b0, 4'h9, 8'h00, v, e);
    chk(v, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 4'hA, 8'h55, v, e);
    chk({31'h0, e}, 32'h1);
    wr(4'h4, 8'h01);
  endtask
  task automatic t_tx(input logic [7:0] b, input int nb, input int s, input int p);
    realtime t0;
    far_len = nb;
    wr(4'h3, 8'((nb - 5) | ((s - 1) << 2) | (p << 3)));
    chk({31'h0, TX_DRIVE_EN}, 32'h0);
    wr(4'h0, b);
    wait_for(TXD, 1'b0, 200);
    t0 = $realtime;
    @(posedge CLK);
    rd(4'h5, 32'h20);
    wait_for(TX_DRIVE_EN, 1'b0, 40000);
    chk(32'(int'(($realtime - t0) / bit_ns)), 32'(1 + nb + s + p));
    chk({24'h0, far_got}, {24'h0, b & 8'((1 << nb) - 1)});
    @(posedge CLK);
  endtask
  task automatic t_rx;
    wr(4'h7, 8'h00);
    wr(4'h1, 8'h01);
    i_dspu_far_end.send(8'h3C);
    @(posedge CLK);
    rd(4'h5, 32'h61);
    chk({31'h0, IRQ}, 32'h0);
    rd(4'h2, 32'h04);
    rd(4'h8, 32'h01);
    wr(4'h7, 8'h01);
    // Interrupt output lags the mask by one cycle
    @(negedge CLK);
    chk({31'h0, IRQ}, 32'h1);
    rd(4'h0, 32'h3C);
    rd(4'h5, 32'h60);
    rd(4'h2, 32'h01);
    chk({31'h0, IRQ}, 32'h1);
    wr(4'h6, 8'h01);
    @(negedge CLK);
    chk({31'h0, IRQ}, 32'h0);
    wr(4'h1, 8'h00);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    CLK = 1'b0;
    RESET = 1'b1;
    {PSEL, PENABLE, PWRITE, QUAD_RANGE} = 4'h0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    bit_ns = 1000.0;
    far_len = 8;
    mismatches = 0;
    comparisons = 0;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    t_regs;
    set_div(8'h01, 1'b1);
    for (n = 5; n <= 8; n++)
      t_tx(8'hA5, n, 1 + (n & 1), n == 7);
    t_rx;
    set_div(8'h0C, 1'b0);
    t_tx(8'h5A, 8, 1, 0);
    test_done;
  end
  // Longest frame is near 2.1 ms; allow ample margin
  initial
  begin
    #10000000;
    mismatches++;
    test_done;
  end
endmodule
